// File: hdl/fpcr_defs.vh
// fpcr_defs.vh: constants shared by the four-phase capture ram files
// assumes inclusion by bare name from the design files
`ifndef FPCR_DEFS_VH
`define FPCR_DEFS_VH

`define FPCR_SEC_WORDS     256
`define FPCR_DATA_W        8
`define FPCR_ADDR_W        8
`define FPCR_ADDR_TOP      8'hFF
`define FPCR_ADDR_BOT      8'h00
`define FPCR_NPHASE        4
`define FPCR_PH_W          2
`define FPCR_PH_LAST       2'h3
`define FPCR_SYNC_W        3
`define FPCR_ADR_MSB       7

// wishbone register word offsets (byte addresses)
`define FPCR_REG_CTRL      4'h0
`define FPCR_REG_STAT      4'h4
`define FPCR_REG_PRESET    4'h8
`define FPCR_REG_SWCLK     4'hC
`define FPCR_REG_DATA      4'h0
`define FPCR_ADR_HI        5
`define FPCR_ADR_LO        2

// control register fields
`define FPCR_CTL_COLLECT   0
`define FPCR_CTL_PRESET_N  1
`define FPCR_CTL_STRB_HI   2
`define FPCR_CTL_SRC_WAVE  3
`define FPCR_CTL_SRC_TEST  4
`define FPCR_CTL_SECT_LO   8
`define FPCR_CTL_SECT_HI   9
`define FPCR_CTL_TP_LO     16
`define FPCR_CTL_TP_HI     23
`define FPCR_CTL_RESET     32'h0000_0002

// status fields
`define FPCR_ST_CARRY      5
`define FPCR_ST_OVF        6
`define FPCR_ST_DONE       7
`define FPCR_ST_PH_LO      8
`define FPCR_ST_PH_HI      9
`define FPCR_ST_ADR_LO     16
`define FPCR_ST_ADR_HI     23

`endif

// File: hdl/fpcr_section.v
// fpcr_section.v: one 256 x 8 capture section with active-low write strobe
// assumes the strobe and address are registered in the same clock domain
`timescale 1ns/1ps
`include "fpcr_defs.vh"

module fpcr_section (
  input  wire                      i_mclk,
  input  wire                      i_ce,
  input  wire                      i_we_n,
  input  wire [`FPCR_ADDR_W-1:0]   i_addr,
  input  wire [`FPCR_DATA_W-1:0]   i_wdata,
  output reg  [`FPCR_DATA_W-1:0]   o_rdata
);

  reg [`FPCR_DATA_W-1:0] mem [0:`FPCR_SEC_WORDS-1];

  // write only while chip enabled and strobe low; read is synchronous
  always @(posedge i_mclk) begin
    if (i_ce && !i_we_n) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule // fpcr_section

// File: hdl/fpcr_capture_ram.v
// fpcr_capture_ram.v: four-phase interleaved capture memory with a
// down-counting address counter, delayed b-side latch, rollover flag and
// a wishbone register port for preset, software clock and readback.
// assumes: sampled data and trigger arrive synchronous to i_mclk (one
// sample per clock); collection start/stop comes from software control.
`timescale 1ns/1ps
`include "fpcr_defs.vh"

module fpcr_capture_ram (
  input  wire                      i_mclk,
  input  wire                      i_rst_n,
  // sampled inputs, same clock domain
  input  wire [`FPCR_DATA_W-1:0]   i_probe_data,
  input  wire [`FPCR_DATA_W-1:0]   i_wave_data,
  input  wire                      i_trigger_match,
  // classic wishbone slave
  input  wire                      i_wb_cyc,
  input  wire                      i_wb_stb,
  input  wire                      i_wb_we,
  input  wire [`FPCR_ADR_HI:0]     i_wb_adr,
  input  wire [3:0]                i_wb_sel,
  input  wire [31:0]               i_wb_dat,
  output reg  [31:0]               o_wb_dat,
  output reg                       o_wb_ack,
  // observation of the phase timing
  output reg  [`FPCR_NPHASE-1:0]   o_phase_clocks,
  output wire [`FPCR_NPHASE-1:0]   o_phase_write_strobes,
  output reg  [`FPCR_ADDR_W-1:0]   o_a_side_addr,
  output reg  [`FPCR_ADDR_W-1:0]   o_b_side_addr,
  output reg                       o_overflow,
  output reg                       o_trigger_seen
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // one nibble stage of the cascaded down counter
  function [4:0] nib_dec;
    input [3:0] v;
    input       cin;
    begin
      nib_dec = {1'b0, v} - {4'h0, cin};
    end
  endfunction

  // byte lane merge for control writes
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer k;
    begin
      lane_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [31:0]              ctrl_r;
  reg  [`FPCR_ADDR_W-1:0]  cnt_r;
  reg                      cnt_carry_r;
  reg  [`FPCR_PH_W-1:0]    phase_r;
  reg  [`FPCR_PH_W-1:0]    last_phase_r;
  reg  [`FPCR_DATA_W-1:0]  hold_data_r [0:`FPCR_NPHASE-1];
  reg  [`FPCR_NPHASE-1:0]  strobe_n_r;
  reg                      msb_d_r;
  reg                      collect_d_r;
  reg  [31:0]              status_r;
  reg                      rd_wait_r;

  wire                     collect     = ctrl_r[`FPCR_CTL_COLLECT];
  wire                     preset_n    = ctrl_r[`FPCR_CTL_PRESET_N];
  wire                     strobes_hi  = ctrl_r[`FPCR_CTL_STRB_HI];
  wire [1:0]               rd_sect     = ctrl_r[`FPCR_CTL_SECT_HI:`FPCR_CTL_SECT_LO];
  wire [`FPCR_DATA_W-1:0]  test_bits   = ctrl_r[`FPCR_CTL_TP_HI:`FPCR_CTL_TP_LO];

  wire                     wb_req      = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // only the two register-select bits form the offset; the memory window is
  // told apart by the top address bit alone, so writes there alias registers
  wire [3:0]               wb_off      = {i_wb_adr[`FPCR_ADR_LO+1:`FPCR_ADR_LO], 2'b00};
  wire                     wr_ctrl     = wb_req && i_wb_we && (wb_off == `FPCR_REG_CTRL);
  wire                     wr_preset   = wb_req && i_wb_we && (wb_off == `FPCR_REG_PRESET);
  wire                     sw_clk      = wb_req && i_wb_we && (wb_off == `FPCR_REG_SWCLK);
  wire                     rd_data     = wb_req && !i_wb_we && i_wb_adr[`FPCR_ADR_HI];

  reg  [`FPCR_ADDR_W-1:0]  preset_bits_r;

  ////////////////////////////////////////////////////////////////////////
  // sampler source select

  // test pattern wins over waveform source when both are set; probe is the default path
  reg [`FPCR_DATA_W-1:0] sample_in;
  always @* begin
    if (ctrl_r[`FPCR_CTL_SRC_WAVE]) begin
      sample_in = ctrl_r[`FPCR_CTL_SRC_TEST] ? test_bits : i_wave_data;
    end else begin
      sample_in = i_probe_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cascaded down counter, low nibble borrows into high nibble

  wire [4:0] lo_dec = nib_dec(cnt_r[3:0], 1'b1);
  wire [4:0] hi_dec = nib_dec(cnt_r[7:4], lo_dec[4]);
  wire [`FPCR_ADDR_W-1:0] cnt_dec = {hi_dec[3:0], lo_dec[3:0]};

  // the counter steps once per four samples while collecting, else only on
  // the software clock; the fast path is never used after capture
  wire step_fast = collect && (phase_r == `FPCR_PH_LAST);
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_r       <= `FPCR_ADDR_TOP;
      cnt_carry_r <= 1'b1;
    end else if (step_fast) begin
      cnt_r       <= cnt_dec;
      cnt_carry_r <= (cnt_r != `FPCR_ADDR_BOT);
    end else if (!collect && sw_clk) begin
      if (!preset_n) begin
        cnt_r       <= ~preset_bits_r;
        cnt_carry_r <= 1'b1;
      end else begin
        cnt_r       <= cnt_dec;
        cnt_carry_r <= (cnt_r != `FPCR_ADDR_BOT);
      end
    end
  end

  // preset address bits held by software, loaded on the next clock pulse
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      preset_bits_r <= `FPCR_ADDR_BOT;
    end else if (wr_preset && i_wb_sel[0]) begin
      preset_bits_r <= i_wb_dat[`FPCR_ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // four-phase generator and data holding

  // phase counter walks one sample per clock, giving each phase a quarter rate
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      phase_r        <= 2'h0;
      last_phase_r   <= 2'h0;
      o_phase_clocks <= 4'h1;
    end else if (collect) begin
      phase_r        <= phase_r + 2'h1;
      last_phase_r   <= phase_r;
      o_phase_clocks <= {o_phase_clocks[2:0], o_phase_clocks[3]};
    end
  end

  // each phase register keeps its word for four samples toward its section
  integer p;
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      for (p = 0; p < `FPCR_NPHASE; p = p + 1) begin
        hold_data_r[p] <= 8'h00;
      end
    end else if (collect) begin
      hold_data_r[phase_r] <= sample_in;
    end
  end

  // strobe of each phase goes low on the same edge its data is held; forced
  // high outside collection so readback never corrupts memory
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      strobe_n_r <= 4'hF;
    end else if (!collect || strobes_hi) begin
      strobe_n_r <= 4'hF;
    end else begin
      strobe_n_r <= ~(4'h1 << phase_r);
    end
  end
  assign o_phase_write_strobes = strobe_n_r;

  ////////////////////////////////////////////////////////////////////////
  // a-side and delayed b-side addresses

  // a side follows the counter; b side copies it one clock later, and on
  // the software clock edge the copy is skipped while the counter moves
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_a_side_addr <= `FPCR_ADDR_TOP;
      o_b_side_addr <= `FPCR_ADDR_TOP;
    end else begin
      o_a_side_addr <= cnt_r;
      if ((collect && phase_r[0]) || (!collect && !sw_clk)) begin
        o_b_side_addr <= o_a_side_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sections

  wire [`FPCR_DATA_W-1:0] sect_q [0:`FPCR_NPHASE-1];
  genvar g;
  generate
    for (g = 0; g < `FPCR_NPHASE; g = g + 1) begin : g_sect
      fpcr_section u_sect (
        .i_mclk  (i_mclk),
        .i_ce    (collect || (rd_sect == g)),
        .i_we_n  (strobe_n_r[g]),
        .i_addr  ((g < 2) ? o_a_side_addr : o_b_side_addr),
        .i_wdata (hold_data_r[g]),
        .o_rdata (sect_q[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // rollover flag and trigger

  // the software address is the inverted count, so its msb falls exactly
  // when the count wraps from 00 back to FF; a count msb fall at 80 to 7F
  // is only half way round and must not claim that old data was lost
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      msb_d_r        <= 1'b1;
      o_overflow     <= 1'b0;
      o_trigger_seen <= 1'b0;
    end else begin
      msb_d_r <= cnt_r[`FPCR_ADR_MSB];
      if (!msb_d_r && cnt_r[`FPCR_ADR_MSB] && collect) begin
        o_overflow <= 1'b1;
      end else if (wr_preset) begin
        o_overflow <= 1'b0;
      end
      if (collect && i_trigger_match) begin
        o_trigger_seen <= 1'b1;
      end else if (wr_preset) begin
        o_trigger_seen <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status capture at end of collection

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      collect_d_r <= 1'b0;
      status_r    <= 32'h0000_0000;
    end else begin
      collect_d_r <= collect;
      if (collect_d_r && !collect) begin
        status_r <= 32'h0000_0000;
        status_r[`FPCR_ST_ADR_HI:`FPCR_ST_ADR_LO] <= cnt_r;
        status_r[`FPCR_ST_PH_HI:`FPCR_ST_PH_LO]   <= last_phase_r;
        status_r[`FPCR_ST_OVF]                    <= o_overflow;
        status_r[`FPCR_ST_DONE]                   <= 1'b1;
      end else if (collect) begin
        status_r[`FPCR_ST_DONE] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and wishbone answer

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_r <= `FPCR_CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= lane_merge(ctrl_r, i_wb_dat, i_wb_sel);
    end
  end

  // register reads answer next cycle; memory reads wait one more cycle for
  // the synchronous section output
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_wb_ack  <= 1'b0;
      o_wb_dat  <= 32'h0000_0000;
      rd_wait_r <= 1'b0;
    end else begin
      o_wb_ack <= 1'b0;
      if (rd_wait_r) begin
        rd_wait_r <= 1'b0;
        o_wb_ack  <= 1'b1;
        o_wb_dat  <= {24'h00_0000, sect_q[rd_sect]};
      end else if (rd_data) begin
        rd_wait_r <= 1'b1;
      end else if (wb_req) begin
        o_wb_ack <= 1'b1;
        o_wb_dat <= 32'h0000_0000;
        if (!i_wb_we) begin
          case (wb_off)
            `FPCR_REG_CTRL: begin
              o_wb_dat <= ctrl_r;
            end
            `FPCR_REG_STAT: begin
              o_wb_dat <= status_r | ({31'h0, cnt_carry_r} << `FPCR_ST_CARRY);
            end
            `FPCR_REG_PRESET: begin
              o_wb_dat <= {24'h00_0000, cnt_r};
            end
            default: begin
              o_wb_dat <= {31'h0, o_overflow};
            end
          endcase
        end
      end
    end
  end

endmodule // fpcr_capture_ram

// File: bench/fpcr_capture_ram_monitor.sv
// fpcr_capture_ram_monitor.sv: port-level checks of the capture memory
// assumes bind to fpcr_capture_ram, one clock, sync active-low reset
`timescale 1ns/1ps
module fpcr_capture_ram_monitor (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_wb_stb,
  input wire logic       o_wb_ack,
  input wire logic [3:0] o_phase_clocks,
  input wire logic [3:0] o_phase_write_strobes,
  input wire logic [7:0] o_a_side_addr,
  input wire logic [7:0] o_b_side_addr,
  input wire logic       o_overflow
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] ph_r;
  logic [7:0] a_r;
  // one-cycle copies, so relations read against the previous cycle
  always @(posedge i_mclk) begin
    ph_r <= o_phase_clocks;
    a_r  <= o_a_side_addr;
  end
  ////////////////////////////////////////////////////////////////////////
  a_phase_onehot: assert property ($onehot(o_phase_clocks))
    else $error("phase clocks not one-hot");
  a_phase_rotate: assert property ($changed(o_phase_clocks) |->
    o_phase_clocks == {ph_r[2:0], ph_r[3]}) else $error("phase order wrong");
  a_one_strobe: assert property ($countones(~o_phase_write_strobes) <= 1)
    else $error("two write strobes low together");
  a_b_follows: assert property (o_b_side_addr == a_r)
    else $error("b side not one step behind a side");
  a_addr_step: assert property ($changed(o_a_side_addr) |->
    (o_a_side_addr == a_r - 8'h01) || o_wb_ack || $past(o_wb_ack))
    else $error("address moved other than down by one");
  a_ovf_cause: assert property ($rose(o_overflow) |-> o_a_side_addr == 8'hFF)
    else $error("overflow set without wrap");
  a_ovf_sticky: assert property ($fell(o_overflow) |->
    o_wb_ack || $past(o_wb_ack)) else $error("overflow cleared by itself");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack without request");
  c_ovf: cover property ($rose(o_overflow));
  c_strobe: cover property (o_phase_write_strobes != 4'hF);
  c_wrap: cover property (o_a_side_addr == 8'h00 ##1 o_a_side_addr == 8'hFF);
endmodule // fpcr_capture_ram_monitor

bind fpcr_capture_ram fpcr_capture_ram_monitor i_mon (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .o_phase_clocks(o_phase_clocks), .o_phase_write_strobes(o_phase_write_strobes),
  .o_a_side_addr(o_a_side_addr), .o_b_side_addr(o_b_side_addr),
  .o_overflow(o_overflow));

// File: bench/fpcr_sampler_model.sv
// fpcr_sampler_model.sv: front-end sampler feeding one word per clock
// assumes the bench picks the level; waveform lane carries its inverse
`timescale 1ns/1ps
module fpcr_sampler_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_level,
  output logic [7:0]      o_probe_data,
  output logic [7:0]      o_wave_data,
  output logic            o_trigger_match
);
  logic [9:0] cnt_r = 10'h000;
  initial begin
    o_probe_data = 8'h00;
    o_wave_data = 8'hFF;
    o_trigger_match = 1'b0;
  end
  // lanes differ so a wrong source select cannot pass unseen
  always @(posedge i_mclk) begin
    cnt_r <= cnt_r + 10'h001;
    o_probe_data <= i_level;
    o_wave_data <= ~i_level;
    o_trigger_match <= (cnt_r == 10'h3FF);
  end
endmodule // fpcr_sampler_model

// File: bench/test_four_phase_capture_ram.sv
// test_four_phase_capture_ram.sv: self-checking bench of the capture ram
// assumes a wishbone master here and the sampler model on the data side
`timescale 1ns/1ps
module test_four_phase_capture_ram;
  logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, ovf, trg, tsn;
  logic [7:0] lvl = 8'hA5, pd, wd, aa, ba;
  logic [3:0] ph, wst;
  int miscompares = 0, n_tests = 0;
  always #4 mclk = ~mclk;
  fpcr_sampler_model i_smp (.i_mclk(mclk), .i_level(lvl), .o_probe_data(pd),
    .o_wave_data(wd), .o_trigger_match(trg));
  fpcr_capture_ram i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_probe_data(pd),
    .i_wave_data(wd), .i_trigger_match(trg), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_phase_clocks(ph),
    .o_phase_write_strobes(wst), .o_a_side_addr(aa), .o_b_side_addr(ba),
    .o_overflow(ovf), .o_trigger_seen(tsn));
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
  endtask
  // load a start address: preset low, address, one software clock
  task automatic load(input logic [7:0] a);
    wb(1, 6'h00, 32'h0);
    wb(1, 6'h08, {24'h0, a});
    wb(1, 6'h0C, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wb(0, 6'h00, 32'h0);
    chk(q, 32'h2);
    chk({wst, aa}, 12'hFFF);
  endtask
  task automatic t_preset;
    load(8'h05);
    repeat (3) @(posedge mclk);
    chk(aa, 8'hFA);
    wb(0, 6'h08, 32'h0);
    chk(q[7:0], 8'hFA);
    wb(1, 6'h00, 32'h2);
    wb(1, 6'h0C, 32'h0);
    repeat (3) @(posedge mclk);
    chk({aa, ba}, 16'hF9F9);
  endtask
  task automatic t_collect(input logic [31:0] ctl, input logic [7:0] exp);
    int lows;
    lows = 0;
    load(8'h00);
    wb(1, 6'h00, ctl | 32'h3);
    repeat (1100) begin
      @(posedge mclk);
      if (wst !== 4'hF) lows++;
    end
    chk(lows > 0, 1);
    chk(ovf, 1);
    chk(tsn, 1);
    wb(1, 6'h00, ctl | 32'h7);
    repeat (8) @(posedge mclk);
    chk(wst, 4'hF);
    wb(1, 6'h00, 32'h6);
    wb(0, 6'h04, 32'h0);
    chk(q[7:6], 2'h3);
    chk(wst, 4'hF);
    for (int s = 0; s < 4; s++) begin
      wb(1, 6'h00, 32'h6 | (s << 8));
      wb(0, 6'h20, 32'h0);
      chk(q[7:0], exp);
    end
  endtask
  task automatic t_carry;
    int n;
    logic [31:0] st;
    load(8'h00);
    chk(ovf, 0);
    chk(tsn, 0);
    wb(1, 6'h00, 32'h2);
    wb(0, 6'h04, 32'h0);
    st = q;
    wb(1, 6'h04, 32'hFFFFFFFF);
    wb(0, 6'h04, 32'h0);
    chk(q, st);
    n = 0;
    while (q[5] !== 1'b0 && n < 300) begin
      wb(1, 6'h0C, 32'h0);
      n++;
      wb(0, 6'h04, 32'h0);
    end
    chk(n, 256);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    t_reset();
    t_preset();
    t_collect(32'h0, 8'hA5);
    t_collect(32'h8, 8'h5A);
    t_collect(32'h00C3_0018, 8'hC3);
    t_carry();
    finish_test();
  end
endmodule // test_four_phase_capture_ram
